/* logic/dcr_clock_regs.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Overview of operation
// (RL1) software sets low range bit 7 when loop on and clock below 350 MHz
// (RL2) software sets bit 4 for fixed delay line, clears it for loop mode
// (RL3) loop mode advised above 250 MHz, delay line below; advice only
// (RL4) software writes reserved fields with reset value, e.g. nibble 0x6
// (RL5) status bit 6 set while loop is near either end of delay line
// (RL6) status bit 5 set while loop sits at start of delay line
// (RL7) status bit 4 set while loop sits at end of delay line
// (RL8) status bit 2 reads 1 while external capture clock is supplied
// (RL9) status bit 0 reads 1 while loop tries to lock, else 0
// (RL10) sample receiver register resets to 0xff, bit 7 enables duty fix
// (RL11) sample receiver bit 5 enables crosspoint control, on after reset
// (RL12) sample crosspoint level is 5-bit signed, resets to 0x1f
// (RL13) reference receiver resets to 0x5f, bit 7 duty fix off by default
// (RL14) reference receiver bit 5 enables crosspoint, off after reset
// (RL15) reference crosspoint level in bits 4:0, resets to 0x1f
// (RL16) pll bit 6 picks band selection: 0 automatic, 1 manual; reset 0
// (RL17) six-bit manual band field picks one of 64 bands, resets zero
// (RL18) writing 1 to clear bit of 0x0b clears status bits 6 to 4
// (RL19) status register reserved bits read zero, writes to it ignored
// ----------------------------------------------------------------------------
module dcr_clock_regs (
  // clock and control
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // serial control port
  input  wire logic spi_cs_n,
  input  wire logic spi_sclk,
  input  wire logic spi_sdio_in,
  output logic      spi_sdio_out,
  output logic      spi_sdio_oe_n,
  // capture loop state from the analog side
  input  wire logic loop_locked,
  input  wire logic loop_near_edge,
  input  wire logic loop_at_start,
  input  wire logic loop_at_end,
  input  wire logic capture_clock_present,
  input  wire logic loop_running,
  // capture configuration
  output logic      low_capture_clock_range,
  output logic      delay_line_mode_sel,
  // sample clock receiver
  output logic      sample_clk_duty_fix_en,
  output logic      sample_clk_xpoint_en,
  output logic [4:0] sample_clk_xpoint_level,
  // reference clock receiver
  output logic      ref_clk_duty_fix_en,
  output logic      ref_clk_xpoint_en,
  output logic [4:0] ref_clk_xpoint_level,
  // pll band selection
  output logic      pll_enable,
  output logic      pll_band_manual,
  output logic [5:0] pll_manual_band
);

  // ------------------------------------------------------------------------
  // register state
  // ------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] capture_cfg;
    logic [7:0] sample_rx;
    logic [7:0] ref_rx;
    logic [7:0] pll_band;
  } dcr_regs_st_t;

  dcr_regs_st_t cur_ff;
  dcr_regs_st_t nxt_cur;

  logic [6:0]   rd_addr;
  logic [7:0]   rd_data;
  logic         wr_en;
  logic [6:0]   wr_addr;
  logic [7:0]   wr_data;
  logic         warn_clr;
  logic         edge_evt;
  logic         warn_edge;
  logic         warn_start;
  logic         warn_end;
  logic [7:0]   status_byte;

  // ------------------------------------------------------------------------
  // serial port
  // ------------------------------------------------------------------------
  dcr_spi_slave u_spi (
    .clk           (clk),
    .rst           (rst),
    .ce            (ce),
    .spi_cs_n      (spi_cs_n),
    .spi_sclk      (spi_sclk),
    .spi_sdio_in   (spi_sdio_in),
    .spi_sdio_out  (spi_sdio_out),
    .spi_sdio_oe_n (spi_sdio_oe_n),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data)
  );

  // ------------------------------------------------------------------------
  // warning flags
  // ------------------------------------------------------------------------
  // clear strobe decoded from the neighbouring control register; that
  // register's storage lives elsewhere, only the clear bit acts here
  assign warn_clr = ce && wr_en && wr_addr == dcr_pkg::OFS_WARN_CLEAR
                    && wr_data[dcr_pkg::BIT_WARN_CLEAR]; // RL18

  // sitting at either end also counts as being near an end
  assign edge_evt = loop_near_edge | loop_at_start | loop_at_end; // RL5

  dcr_sticky_flag u_warn_edge (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .set_evt (edge_evt),
    .clr     (warn_clr),
    .flag    (warn_edge)
  );

  dcr_sticky_flag u_warn_start (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .set_evt (loop_at_start), // RL6
    .clr     (warn_clr),
    .flag    (warn_start)
  );

  dcr_sticky_flag u_warn_end (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .set_evt (loop_at_end), // RL7
    .clr     (warn_clr),
    .flag    (warn_end)
  );

  // ------------------------------------------------------------------------
  // status byte
  // ------------------------------------------------------------------------
  // live bits come straight from the loop; reserved bits are tied low
  always_comb begin
    status_byte = 8'h00; // RL19
    status_byte[dcr_pkg::BIT_LOCK]        = loop_locked;
    status_byte[dcr_pkg::BIT_EDGE_WARN]   = warn_edge; // RL5
    status_byte[dcr_pkg::BIT_START_WARN]  = warn_start; // RL6
    status_byte[dcr_pkg::BIT_END_WARN]    = warn_end; // RL7
    status_byte[dcr_pkg::BIT_CLK_PRESENT] = capture_clock_present; // RL8
    status_byte[dcr_pkg::BIT_RUNNING]     = loop_running; // RL9
  end

  // ------------------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------------------
  // unmapped addresses, the clear register included, read as zero
  always_comb begin
    if (rd_addr == dcr_pkg::OFS_CAPTURE_CFG) begin
      rd_data = cur_ff.capture_cfg;
    end else if (rd_addr == dcr_pkg::OFS_CAPTURE_STAT) begin
      rd_data = status_byte;
    end else if (rd_addr == dcr_pkg::OFS_SAMPLE_RX) begin
      rd_data = cur_ff.sample_rx;
    end else if (rd_addr == dcr_pkg::OFS_REF_RX) begin
      rd_data = cur_ff.ref_rx;
    end else if (rd_addr == dcr_pkg::OFS_PLL_BAND) begin
      rd_data = cur_ff.pll_band;
    end else begin
      rd_data = dcr_pkg::RD_UNMAPPED;
    end
  end

  // ------------------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------------------
  // reserved fields are stored as written; software is trusted to keep
  // them at their reset values, the bank does not force them
  always_comb begin
    nxt_cur = cur_ff;
    if (ce && wr_en) begin
      if (wr_addr == dcr_pkg::OFS_CAPTURE_CFG) begin
        nxt_cur.capture_cfg = wr_data; // RL4
      end else if (wr_addr == dcr_pkg::OFS_SAMPLE_RX) begin
        nxt_cur.sample_rx = wr_data;
      end else if (wr_addr == dcr_pkg::OFS_REF_RX) begin
        nxt_cur.ref_rx = wr_data;
      end else if (wr_addr == dcr_pkg::OFS_PLL_BAND) begin
        nxt_cur.pll_band = wr_data;
      end else begin
        nxt_cur = cur_ff; // status is read-only RL19
      end
    end
  end

  // reset wins over a low clock enable
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ff.capture_cfg <= dcr_pkg::RST_CAPTURE_CFG;
      cur_ff.sample_rx   <= dcr_pkg::RST_SAMPLE_RX; // RL10
      cur_ff.ref_rx      <= dcr_pkg::RST_REF_RX; // RL13
      cur_ff.pll_band    <= dcr_pkg::RST_PLL_BAND; // RL16
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ------------------------------------------------------------------------
  // configuration outputs
  // ------------------------------------------------------------------------
  // software picks these to suit the capture clock rate
  assign low_capture_clock_range =
    cur_ff.capture_cfg[dcr_pkg::BIT_LOW_RANGE]; // RL1
  assign delay_line_mode_sel =
    cur_ff.capture_cfg[dcr_pkg::BIT_DELAY_LINE]; // RL2

  // receiver trims
  assign sample_clk_duty_fix_en =
    cur_ff.sample_rx[dcr_pkg::BIT_DUTY_FIX]; // RL10
  assign sample_clk_xpoint_en =
    cur_ff.sample_rx[dcr_pkg::BIT_XPOINT_EN]; // RL11
  assign sample_clk_xpoint_level =
    cur_ff.sample_rx[dcr_pkg::XPOINT_MSB:0]; // RL12
  assign ref_clk_duty_fix_en =
    cur_ff.ref_rx[dcr_pkg::BIT_DUTY_FIX]; // RL13
  assign ref_clk_xpoint_en =
    cur_ff.ref_rx[dcr_pkg::BIT_XPOINT_EN]; // RL14
  assign ref_clk_xpoint_level =
    cur_ff.ref_rx[dcr_pkg::XPOINT_MSB:0]; // RL15

  // band field is only meaningful while manual selection is on
  assign pll_enable      = cur_ff.pll_band[dcr_pkg::BIT_PLL_ENABLE];
  assign pll_band_manual = cur_ff.pll_band[dcr_pkg::BIT_BAND_MANUAL]; // RL16
  assign pll_manual_band = cur_ff.pll_band[dcr_pkg::BAND_MSB:0]; // RL17

  // ------------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------------
  default clocking dcr_regs_cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_sample_rx_reset: assert property ( // RL10
    $fell(rst) |-> sample_clk_duty_fix_en && sample_clk_xpoint_en
                   && sample_clk_xpoint_level == 5'h1f)
    else $error("sample receiver not at reset value");

  chk_ref_rx_reset: assert property ( // RL13
    $fell(rst) |-> !ref_clk_duty_fix_en && !ref_clk_xpoint_en
                   && ref_clk_xpoint_level == 5'h1f
                   && cur_ff.ref_rx == 8'h5f)
    else $error("reference receiver not at reset value");

  chk_pll_band_reset: assert property ( // RL17
    $fell(rst) |-> !pll_band_manual && pll_manual_band == 6'h00)
    else $error("pll band control not at reset value");

  chk_pll_write_lands: assert property ( // RL16
    ce && wr_en && wr_addr == dcr_pkg::OFS_PLL_BAND
    |=> pll_band_manual == $past(wr_data[6])
        && pll_manual_band == $past(wr_data[5:0]))
    else $error("pll band write not applied");

  chk_status_reserved: assert property ( // RL19
    rd_addr == dcr_pkg::OFS_CAPTURE_STAT |-> rd_data[3] == 1'b0
    && rd_data[1] == 1'b0)
    else $error("status reserved bit reads one");

  chk_running_bit: assert property ( // RL9
    rd_addr == dcr_pkg::OFS_CAPTURE_STAT
    |-> rd_data[0] == loop_running && rd_data[2] == capture_clock_present)
    else $error("status live bits wrong");

  chk_start_warn: assert property ( // RL6
    ce && loop_at_start |=> warn_start && warn_edge)
    else $error("start warning not raised");

  chk_end_warn: assert property ( // RL7
    ce && loop_at_end ##1 !ce [*2] |-> warn_end && warn_edge)
    else $error("end warning lost while frozen");

  chk_clear_warns: assert property ( // RL18
    warn_clr && !edge_evt |=> !warn_edge && !warn_start && !warn_end)
    else $error("warnings survived the clear");

  chk_freeze: assert property (
    !ce |=> $stable(cur_ff))
    else $error("registers moved with clock enable low");

  // writes land as sent; the status byte ignores them
  chk_cfg_write_lands: assert property ( // RL4
    ce && wr_en && wr_addr == dcr_pkg::OFS_CAPTURE_CFG
    |=> cur_ff.capture_cfg == $past(wr_data))
    else $error("capture config write not applied");

  chk_status_write_ignored: assert property ( // RL19
    ce && wr_en && wr_addr == dcr_pkg::OFS_CAPTURE_STAT |=> $stable(cur_ff))
    else $error("status write changed a register");

  cov_pll_write: cover property (
    ce && wr_en && wr_addr == dcr_pkg::OFS_PLL_BAND);
  cov_status_read: cover property (
    !spi_sdio_oe_n && rd_addr == dcr_pkg::OFS_CAPTURE_STAT);
  cov_warn_clear: cover property (warn_edge ##1 warn_clr);
  cov_frozen_frame: cover property (!ce && !spi_cs_n);

endmodule : dcr_clock_regs

/* logic/dcr_pkg.sv */
// ----------------------------------------------------------------------------
// shared constants for the capture clock and loop register bank
// ----------------------------------------------------------------------------
package dcr_pkg;

  // ------------------------------------------------------------------------
  // register offsets (7-bit serial address)
  // ------------------------------------------------------------------------
  localparam logic [6:0] OFS_WARN_CLEAR   = 7'h0b;
  localparam logic [6:0] OFS_CAPTURE_CFG  = 7'h0d;
  localparam logic [6:0] OFS_CAPTURE_STAT = 7'h0e;
  localparam logic [6:0] OFS_SAMPLE_RX    = 7'h10;
  localparam logic [6:0] OFS_REF_RX       = 7'h11;
  localparam logic [6:0] OFS_PLL_BAND     = 7'h12;

  // ------------------------------------------------------------------------
  // values after reset, and what unmapped addresses read as
  // ------------------------------------------------------------------------
  localparam logic [7:0] RST_CAPTURE_CFG = 8'h06;
  localparam logic [7:0] RST_SAMPLE_RX   = 8'hff;
  localparam logic [7:0] RST_REF_RX      = 8'h5f;
  localparam logic [7:0] RST_PLL_BAND    = 8'h00;
  localparam logic [7:0] RD_UNMAPPED     = 8'h00;

  // ------------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------------
  localparam int BIT_WARN_CLEAR   = 7;
  localparam int BIT_LOW_RANGE    = 7;
  localparam int BIT_DELAY_LINE   = 4;
  localparam int BIT_LOCK         = 7;
  localparam int BIT_EDGE_WARN    = 6;
  localparam int BIT_START_WARN   = 5;
  localparam int BIT_END_WARN     = 4;
  localparam int BIT_CLK_PRESENT  = 2;
  localparam int BIT_RUNNING      = 0;
  localparam int BIT_DUTY_FIX     = 7;
  localparam int BIT_XPOINT_EN    = 5;
  localparam int XPOINT_MSB       = 4;
  localparam int BIT_PLL_ENABLE   = 7;
  localparam int BIT_BAND_MANUAL  = 6;
  localparam int BAND_MSB         = 5;

  // ------------------------------------------------------------------------
  // serial port framing
  // ------------------------------------------------------------------------
  localparam logic [2:0] SPI_LAST_BIT = 3'h7;

  typedef enum logic [0:0] {
    SPI_INSTR = 1'b0,
    SPI_DATA  = 1'b1
  } dcr_spi_state_t;

endpackage : dcr_pkg

/* logic/dcr_sticky_flag.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// one sticky warning flag: set by hardware, cleared by software
// ----------------------------------------------------------------------------
module dcr_sticky_flag (
  // clock and control
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // event and clear
  input  wire logic set_evt,
  input  wire logic clr,
  // flag out
  output logic      flag
);

  typedef struct packed {
    logic flag;
  } dcr_flag_st_t;

  dcr_flag_st_t cur_ff;
  dcr_flag_st_t nxt_cur;

  // set wins over a clear in the same cycle so no event is lost
  always_comb begin
    nxt_cur = cur_ff;
    if (ce) begin
      nxt_cur.flag = set_evt | (cur_ff.flag & ~clr);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign flag = cur_ff.flag;

  default clocking dcr_flag_cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_flag_set_wins: assert property (ce && set_evt |=> flag) // RL6
    else $error("flag missed its event");
  chk_flag_clear: assert property (ce && clr && !set_evt |=> !flag) // RL18
    else $error("flag survived a clear");

endmodule : dcr_sticky_flag

/* logic/dcr_spi_slave.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// three-wire serial control port: instruction byte, then data bytes
// ----------------------------------------------------------------------------
module dcr_spi_slave (
  // clock and control
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // serial pins, sampled on clk
  input  wire logic       spi_cs_n,
  input  wire logic       spi_sclk,
  input  wire logic       spi_sdio_in,
  output logic            spi_sdio_out,
  output logic            spi_sdio_oe_n,
  // register side
  output logic [6:0]      rd_addr,
  input  wire logic [7:0] rd_data,
  output logic            wr_en,
  output logic [6:0]      wr_addr,
  output logic [7:0]      wr_data
);

  typedef struct packed {
    dcr_pkg::dcr_spi_state_t st;
    logic                    sclk_q;
    logic [2:0]              cnt;
    logic                    rw;
    logic [6:0]              addr;
    logic [7:0]              sh_in;
    logic [7:0]              sh_out;
    logic                    sdo;
    logic                    wr_en;
    logic [6:0]              wr_addr;
    logic [7:0]              wr_data;
  } dcr_spi_st_t;

  dcr_spi_st_t cur_ff;
  dcr_spi_st_t nxt_cur;
  logic        rise;
  logic        fall;

  // ------------------------------------------------------------------------
  // sclk edges seen in the clk domain
  // ------------------------------------------------------------------------
  assign rise = spi_sclk & ~cur_ff.sclk_q;
  assign fall = ~spi_sclk & cur_ff.sclk_q;

  // ------------------------------------------------------------------------
  // frame engine
  // ------------------------------------------------------------------------
  // sample on rising sclk, drive on falling sclk; address steps per byte
  always_comb begin
    nxt_cur = cur_ff;
    if (ce) begin
      nxt_cur.wr_en  = 1'b0;
      nxt_cur.sclk_q = spi_sclk;
      if (spi_cs_n) begin
        nxt_cur.st  = dcr_pkg::SPI_INSTR;
        nxt_cur.cnt = '0;
      end else if (rise) begin
        nxt_cur.sh_in = {cur_ff.sh_in[6:0], spi_sdio_in};
        nxt_cur.cnt   = cur_ff.cnt + 3'h1;
        if (cur_ff.cnt == dcr_pkg::SPI_LAST_BIT) begin
          case (cur_ff.st)
            dcr_pkg::SPI_INSTR: begin
              nxt_cur.st   = dcr_pkg::SPI_DATA;
              nxt_cur.rw   = cur_ff.sh_in[6]; // 1 = read
              nxt_cur.addr = {cur_ff.sh_in[5:0], spi_sdio_in};
            end
            default: begin
              nxt_cur.wr_en   = ~cur_ff.rw;
              nxt_cur.wr_addr = cur_ff.addr;
              nxt_cur.wr_data = {cur_ff.sh_in[6:0], spi_sdio_in};
              nxt_cur.addr    = cur_ff.addr + 7'h01;
            end
          endcase
        end
      end else if (fall && cur_ff.st == dcr_pkg::SPI_DATA && cur_ff.rw) begin
        if (cur_ff.cnt == '0) begin
          nxt_cur.sdo    = rd_data[7]; // read data captured here
          nxt_cur.sh_out = {rd_data[6:0], 1'b0};
        end else begin
          nxt_cur.sdo    = cur_ff.sh_out[7];
          nxt_cur.sh_out = {cur_ff.sh_out[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ------------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------------
  assign rd_addr       = cur_ff.addr;
  assign wr_en         = cur_ff.wr_en;
  assign wr_addr       = cur_ff.wr_addr;
  assign wr_data       = cur_ff.wr_data;
  assign spi_sdio_out  = cur_ff.sdo;
  // drive only during the data phase of a read frame
  assign spi_sdio_oe_n = ~(~spi_cs_n && cur_ff.st == dcr_pkg::SPI_DATA
                           && cur_ff.rw);

  default clocking dcr_spi_cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_sdio_drive_frame: assert property (!spi_sdio_oe_n |-> !spi_cs_n)
    else $error("sdio driven outside a frame");
  chk_wr_pulse_single: assert property (wr_en && ce |=> !wr_en)
    else $error("write strobe longer than one cycle");

endmodule : dcr_spi_slave

/* dv/dcr_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// host side of the three-wire serial control port
// ----------------------------------------------------------------------
module dcr_host_model (
  // clock
  input  wire logic clk,
  // serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      sdio_drv,
  input  wire logic sdio_wire
);
  // serial clock stands low and select high outside frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdio_drv = 1'b0;
  end

  // one serial bit, each sclk level held two system clocks
  task automatic bit_cycle(input logic d, output logic q);
    sdio_drv = d;
    sclk = 1'b1;
    repeat (2) @(negedge clk);
    q = sdio_wire;
    sclk = 1'b0;
    repeat (2) @(negedge clk);
  endtask : bit_cycle

  // instruction byte then one data byte, msb first
  task automatic xfer(input logic rd, input logic [6:0] addr,
                      input logic [7:0] wdata, output logic [7:0] rdata);
    logic [15:0] frame;
    logic        q;
    frame = {rd, addr, wdata};
    @(negedge clk);
    cs_n = 1'b0;
    @(negedge clk);
    for (int i = 15; i >= 0; i--) begin
      // host lets go during read data: toggle so stale levels never match
      bit_cycle((rd && i < 8) ? ~sdio_drv : frame[i], q);
      if (i < 8) begin
        rdata[i] = q;
      end
    end
    cs_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask : xfer
endmodule : dcr_host_model

/* dv/tb_top.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// bench for the capture clock and loop register bank
// ----------------------------------------------------------------------
module tb_top;
  logic       clk, rst, ce;
  logic       spi_cs_n, spi_sclk, sdio_drv, sdio_wire;
  logic       spi_sdio_out, spi_sdio_oe_n;
  logic       loop_locked, capture_clock_present, loop_running;
  logic [2:0] warn_src;
  logic       low_capture_clock_range, delay_line_mode_sel;
  logic       sample_clk_duty_fix_en, sample_clk_xpoint_en;
  logic [4:0] sample_clk_xpoint_level, ref_clk_xpoint_level;
  logic       ref_clk_duty_fix_en, ref_clk_xpoint_en;
  logic       pll_enable, pll_band_manual;
  logic [5:0] pll_manual_band;
  int         mismatches;
  int         check_count;

  // device owns the shared data line only while its enable is low
  assign sdio_wire = spi_sdio_oe_n ? sdio_drv : spi_sdio_out;

  dcr_clock_regs u_dcr_clock_regs (
    .clk, .rst, .ce, .spi_cs_n, .spi_sclk,
    .spi_sdio_in (sdio_wire), .spi_sdio_out, .spi_sdio_oe_n,
    .loop_locked, .loop_near_edge (warn_src[2]),
    .loop_at_start (warn_src[1]), .loop_at_end (warn_src[0]),
    .capture_clock_present, .loop_running,
    .low_capture_clock_range, .delay_line_mode_sel,
    .sample_clk_duty_fix_en, .sample_clk_xpoint_en,
    .sample_clk_xpoint_level, .ref_clk_duty_fix_en, .ref_clk_xpoint_en,
    .ref_clk_xpoint_level, .pll_enable, .pll_band_manual, .pll_manual_band
  );

  dcr_host_model u_dcr_host_model (
    .clk, .cs_n (spi_cs_n), .sclk (spi_sclk), .sdio_drv, .sdio_wire
  );

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    u_dcr_host_model.xfer(1'b1, a, 8'h00, d);
  endtask : rd

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    u_dcr_host_model.xfer(1'b0, a, d, unused);
  endtask : wr

  // pin image laid out like the register it comes from
  function automatic logic [7:0] pins(input logic [6:0] a);
    case (a)
      dcr_pkg::OFS_CAPTURE_CFG:
        return {low_capture_clock_range, 2'h0, delay_line_mode_sel, 4'h0};
      dcr_pkg::OFS_SAMPLE_RX:
        return {sample_clk_duty_fix_en, 1'b0, sample_clk_xpoint_en,
                sample_clk_xpoint_level};
      dcr_pkg::OFS_REF_RX:
        return {ref_clk_duty_fix_en, 1'b0, ref_clk_xpoint_en,
                ref_clk_xpoint_level};
      default:
        return {pll_enable, pll_band_manual, pll_manual_band};
    endcase
  endfunction : pins

  // reserved bits have no pin, so the mask hides them on that side only
  task automatic look(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic [7:0] m;
    m = (a == dcr_pkg::OFS_CAPTURE_CFG) ? 8'h90 :
        (a == dcr_pkg::OFS_PLL_BAND) ? 8'hff : 8'hbf;
    rd(a, d);
    check("register", d, exp);
    check("pins", pins(a) & m, exp & m);
  endtask : look

  // sticky sources are pulsed, then dropped before the readback
  task automatic pulse(input logic [2:0] v);
    @(negedge clk);
    warn_src = v;
    repeat (3) @(negedge clk);
    warn_src = 3'h0;
  endtask : pulse

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    look(dcr_pkg::OFS_CAPTURE_CFG, dcr_pkg::RST_CAPTURE_CFG);
    look(dcr_pkg::OFS_SAMPLE_RX, dcr_pkg::RST_SAMPLE_RX);
    look(dcr_pkg::OFS_REF_RX, dcr_pkg::RST_REF_RX);
    look(dcr_pkg::OFS_PLL_BAND, dcr_pkg::RST_PLL_BAND);
    $display("test reset values done");
  endtask : t_reset

  task automatic t_config();
    logic [14:0] tbl [9];
    logic [7:0]  d;
    // capture writes keep the reserved nibble at 0x6
    tbl = '{{7'h0d, 8'h86}, {7'h0d, 8'h16}, {7'h10, 8'h4f},
            {7'h10, 8'hff}, {7'h11, 8'hbf}, {7'h11, 8'h5f},
            {7'h12, 8'h40}, {7'h12, 8'h7f}, {7'h12, 8'h80}};
    foreach (tbl[i]) begin
      wr(tbl[i][14:8], tbl[i][7:0]);
      look(tbl[i][14:8], tbl[i][7:0]);
    end
    wr(7'h20, 8'haa);
    rd(7'h20, d);
    check("unmapped", d, dcr_pkg::RD_UNMAPPED);
    $display("test configuration done");
  endtask : t_config

  task automatic t_status();
    logic [7:0] d;
    @(negedge clk);
    {loop_locked, capture_clock_present, loop_running} = 3'h7;
    rd(dcr_pkg::OFS_CAPTURE_STAT, d);
    check("live bits", d, 8'h85);
    pulse(3'h2);
    rd(dcr_pkg::OFS_CAPTURE_STAT, d);
    check("start warning", d, 8'he5);
    wr(dcr_pkg::OFS_CAPTURE_STAT, 8'h0a);
    rd(dcr_pkg::OFS_CAPTURE_STAT, d);
    check("status written", d, 8'he5);
    wr(dcr_pkg::OFS_WARN_CLEAR, 8'hb9);
    rd(dcr_pkg::OFS_CAPTURE_STAT, d);
    check("cleared", d, 8'h85);
    pulse(3'h1);
    rd(dcr_pkg::OFS_CAPTURE_STAT, d);
    check("end warning", d, 8'hd5);
    wr(dcr_pkg::OFS_WARN_CLEAR, 8'hb9);
    pulse(3'h4);
    @(negedge clk);
    {loop_locked, capture_clock_present, loop_running} = 3'h0;
    wr(dcr_pkg::OFS_WARN_CLEAR, 8'h39);
    rd(dcr_pkg::OFS_CAPTURE_STAT, d);
    check("near edge", d, 8'h40);
    wr(dcr_pkg::OFS_WARN_CLEAR, 8'hb9);
    rd(dcr_pkg::OFS_CAPTURE_STAT, d);
    check("all clear", d, 8'h00);
    $display("test status done");
  endtask : t_status

  // ce low must hold every register and flag, then reset mid-run
  task automatic t_freeze();
    logic [7:0] d;
    @(negedge clk);
    warn_src = 3'h1;
    @(negedge clk);
    {ce, warn_src} = 4'h0;
    wr(dcr_pkg::OFS_PLL_BAND, 8'h55);
    pulse(3'h2);
    ce = 1'b1;
    rd(dcr_pkg::OFS_CAPTURE_STAT, d);
    check("frozen status", d, 8'h50);
    look(dcr_pkg::OFS_PLL_BAND, 8'h80);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(dcr_pkg::OFS_CAPTURE_STAT, d);
    check("reset status", d, 8'h00);
    $display("test freeze and reset done");
  endtask : t_freeze

  // ----------------------------------------------------------------------
  // clock, sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    warn_src = 3'h0;
    {loop_locked, capture_clock_present, loop_running} = 3'h0;
    mismatches = 0;
    check_count = 0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_config();
    t_status();
    t_freeze();
    t_reset();
    conclude();
  end

  // a hung run is a failed run
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule : tb_top
